// >>> core_side_monitor.sv
// far-side model of the core control outputs: watchdog and program-memory write pulses
// assumes one-cycle pulses on aclk, counted from the release of aresetn
`timescale 1ns/1ps
module core_side_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pulses from the core
	input wire logic wdt_restart,
	input wire logic wdt_timeout,
	input wire logic pm_write_pulse,
	// pulse counts
	output int restarts,
	output int timeouts,
	output int pm_writes
);
	// watchdog side counts each restart pulse and each timeout pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			restarts <= 0;
			timeouts <= 0;
		end else begin
			restarts <= restarts + int'(wdt_restart === 1'b1);
			timeouts <= timeouts + int'(wdt_timeout === 1'b1);
		end
	end
	// self-programming side accepts one word per pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pm_writes <= 0;
		end else begin
			pm_writes <= pm_writes + int'(pm_write_pulse === 1'b1);
		end
	end
endmodule : core_side_monitor

// >>> cpu_bit_transfer_control_ops.sv
// execution unit for i/o bit, shift, flag, data transfer and core control instructions
// assumes one AXI4-Lite master on aclk; memories are internal flip-flop arrays
// What this block does
// - set-i/o-bit forces addressed bit to one, flags untouched, two cycles
// - clear-i/o-bit forces addressed bit to zero, flags untouched, two cycles
// - set and clear half-carry alone, one cycle each
// - set overflow flag alone in one cycle
// - post-increment load reads at pointer then bumps pointer, two cycles
// - pre-decrement load drops pointer first then reads, two cycles
// - offset load reads pointer plus offset, pointer kept, two cycles
// - direct load reads absolute address into register, two cycles
// - offset store writes register at pointer plus offset, two cycles
// - direct store writes register at absolute address, two cycles, no flags
// - program memory read at z into register, z incremented, three cycles
// - push writes register to stack and moves stack pointer, two cycles
// - pop reads stack top into register and moves stack pointer, two cycles
// - sleep takes one cycle and enters configured low-power mode only when sleep_cfg[SLEEP_EN_BIT] is set
// - watchdog restart clears the watchdog count in one cycle
// - break only signals the debug hook, no flag change
`timescale 1ns/1ps
module cpu_bit_transfer_control_ops
	import cpu_ops_pkg::*;
#(
	parameter int DMEM_DEPTH = 64,
	parameter int PM_DEPTH = 32,
	parameter int WDT_CYCLES = 5000
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// core control
	output logic sleep_active,
	output logic [2:0] sleep_mode,
	output logic wdt_restart,
	output logic wdt_timeout,
	output logic break_hit,
	output logic pm_write_pulse
);
	localparam int DAW = $clog2(DMEM_DEPTH);
	localparam int PAW = $clog2(PM_DEPTH);

	logic [7:0] gpr [32];
	logic [7:0] dmem [DMEM_DEPTH];
	logic [7:0] io_regs [32];
	logic [15:0] pm [PM_DEPTH];
	logic [7:0] status_flags;
	logic [15:0] sp;
	logic [7:0] index;
	logic [3:0] sleep_cfg;
	logic [31:0] wdt_count;
	cmd_type cur;
	cmd_type cmd_in;
	logic busy;
	logic [1:0] cnt;
	logic done;
	logic start;

	// bus write side
	logic aw_full;
	logic w_full;
	logic [AXI_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic wr_mapped;
	logic sw_gpr;
	logic sw_io;
	logic [31:0] rd_word;
	logic rd_ok;

	assign s_axi_awready = !aw_full;
	assign s_axi_wready = !w_full;
	assign wr_go = aw_full && w_full && !s_axi_bvalid;
	assign cmd_in = cmd_type'(w_data);
	assign start = wr_go && aw_addr == CMD_OFFSET && (&w_strb) && !busy;
	assign sw_gpr = wr_go && aw_addr == GPR_DATA_OFFSET && w_strb[0];
	assign sw_io = wr_go && aw_addr == IO_DATA_OFFSET && w_strb[0];
	assign wr_mapped = aw_addr inside {CMD_OFFSET, STATUS_OFFSET, GPR_DATA_OFFSET, INDEX_OFFSET,
		IO_DATA_OFFSET, SP_OFFSET, SLEEP_CFG_OFFSET};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_full <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (wr_go) begin
				w_full <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// bus read side
	assign s_axi_arready = !s_axi_rvalid;
	always_comb begin
		rd_word = '0;
		rd_ok = 1'b1;
		case (s_axi_araddr)
			CMD_OFFSET: rd_word = cur;
			STATUS_OFFSET: rd_word = 32'({break_hit, sleep_active, busy, status_flags});
			GPR_DATA_OFFSET: rd_word = 32'(gpr[index[4:0]]);
			INDEX_OFFSET: rd_word = 32'(index);
			IO_DATA_OFFSET: rd_word = 32'(io_regs[index[4:0]]);
			SP_OFFSET: rd_word = 32'(sp);
			SLEEP_CFG_OFFSET: rd_word = 32'(sleep_cfg);
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// software-side control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			index <= INDEX_RESET;
			sleep_cfg <= SLEEP_CFG_RESET;
		end else if (wr_go && w_strb[0]) begin
			if (aw_addr == INDEX_OFFSET)
				index <= w_data[7:0];
			if (aw_addr == SLEEP_CFG_OFFSET)
				sleep_cfg <= w_data[3:0];
		end
	end
	assign sleep_mode = sleep_cfg[3:1];

	// instruction duration, as extra cycles beyond the first
	function automatic logic [1:0] extra_cycles(op_type op);
		case (op)
			op_set_io_bit, op_clear_io_bit: return 2'(CYCLES_IO_BIT - 1);
			op_load_post_inc, op_load_pre_dec, op_load_with_offset, op_load_direct,
			op_store_with_offset, op_store_direct, op_push, op_pop: return 2'(CYCLES_MEM - 1);
			op_program_memory_read: return 2'(CYCLES_PM_READ - 1);
			op_program_memory_write: return 2'(CYCLES_PM_WRITE - 1);
			default: return 2'(CYCLES_SINGLE - 1);
		endcase
	endfunction : extra_cycles

	// sequencer: busy for exactly the instruction's cycle count, effect on its last cycle
	assign done = busy && cnt == 2'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			cnt <= 2'h0;
			cur <= '0;
		end else if (start) begin
			busy <= 1'b1;
			cnt <= extra_cycles(cmd_in.op);
			cur <= cmd_in;
		end else if (done) begin
			busy <= 1'b0;
		end else if (busy) begin
			cnt <= cnt - 2'h1;
		end
	end

	// pointer pair and effective address
	logic [4:0] ptr_lo;
	logic [4:0] ptr_hi;
	logic [15:0] ptr_val;
	logic [15:0] ea;
	logic [7:0] src;
	logic [7:0] pm_byte;
	logic [4:0] io_addr;
	logic [2:0] bit_sel;
	assign ptr_lo = (cur.op inside {op_program_memory_read, op_program_memory_write}) ? PTR_Z_LOW
		: PTR_X_LOW + {2'h0, cur.ptr, 1'b0};
	assign ptr_hi = ptr_lo + 5'h01;
	assign ptr_val = {gpr[ptr_hi], gpr[ptr_lo]};
	assign src = gpr[cur.rd];
	assign pm_byte = ptr_val[0] ? pm[ptr_val[PAW:1]][15:8] : pm[ptr_val[PAW:1]][7:0];
	assign io_addr = cur.q[4:0];
	assign bit_sel = cur.k[2:0];

	always_comb begin
		case (cur.op)
			op_load_pre_dec: ea = ptr_val - 16'h0001;
			op_load_with_offset, op_store_with_offset: ea = ptr_val + 16'(cur.q);
			op_load_direct, op_store_direct: ea = 16'(cur.k);
			op_push: ea = sp;
			op_pop: ea = sp + 16'h0001;
			default: ea = ptr_val;
		endcase
	end

	// general-purpose registers
	always_ff @(posedge aclk) begin
		if (sw_gpr)
			gpr[index[4:0]] <= w_data[7:0];
		if (done) begin
			case (cur.op)
				op_shift_left_logical: gpr[cur.rd] <= {src[6:0], 1'b0};
				op_shift_right_logical: gpr[cur.rd] <= {1'b0, src[7:1]};
				op_load_post_inc: begin
					gpr[cur.rd] <= dmem[ea[DAW-1:0]];
					{gpr[ptr_hi], gpr[ptr_lo]} <= ptr_val + 16'h0001;
				end
				op_load_pre_dec: begin
					gpr[cur.rd] <= dmem[ea[DAW-1:0]];
					{gpr[ptr_hi], gpr[ptr_lo]} <= ea;
				end
				op_load_with_offset, op_load_direct, op_pop: gpr[cur.rd] <= dmem[ea[DAW-1:0]];
				op_program_memory_read: begin
					gpr[cur.rd] <= pm_byte;
					{gpr[ptr_hi], gpr[ptr_lo]} <= ptr_val + 16'h0001;
				end
				default: ;
			endcase
		end
	end

	// status flags; transfer and control ops leave them alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_flags <= FLAGS_RESET;
		end else if (done) begin
			case (cur.op)
				op_shift_left_logical: begin
					status_flags[FLAG_C] <= src[7];
					status_flags[FLAG_Z] <= src[6:0] == 7'h00;
					status_flags[FLAG_N] <= src[6];
					status_flags[FLAG_V] <= src[6] ^ src[7];
				end
				op_shift_right_logical: begin
					status_flags[FLAG_C] <= src[0];
					status_flags[FLAG_Z] <= src[7:1] == 7'h00;
					status_flags[FLAG_N] <= 1'b0;
					status_flags[FLAG_V] <= src[0];
				end
				op_set_half: status_flags[FLAG_H] <= 1'b1;
				op_clear_half: status_flags[FLAG_H] <= 1'b0;
				op_set_overflow: status_flags[FLAG_V] <= 1'b1;
				default: ;
			endcase
		end
	end

	// data memory and stack
	always_ff @(posedge aclk) begin
		if (done && cur.op inside {op_store_with_offset, op_store_direct, op_push})
			dmem[ea[DAW-1:0]] <= src;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			sp <= 16'(DMEM_DEPTH - 1);
		else if (done && cur.op == op_push)
			sp <= sp - 16'h0001;
		else if (done && cur.op == op_pop)
			sp <= sp + 16'h0001;
	end

	// i/o space
	always_ff @(posedge aclk) begin
		if (sw_io)
			io_regs[index[4:0]] <= w_data[7:0];
		if (done && cur.op == op_set_io_bit)
			io_regs[io_addr][bit_sel] <= 1'b1;
		if (done && cur.op == op_clear_io_bit)
			io_regs[io_addr][bit_sel] <= 1'b0;
	end

	// program memory store
	always_ff @(posedge aclk) begin
		if (done && cur.op == op_program_memory_write)
			pm[ptr_val[PAW:1]] <= {gpr[PM_SRC_HIGH], gpr[PM_SRC_LOW]};
	end

	// core control: sleep, debug hook, watchdog
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_active <= 1'b0;
			break_hit <= 1'b0;
			wdt_restart <= 1'b0;
			pm_write_pulse <= 1'b0;
		end else begin
			if (start)
				sleep_active <= 1'b0;
			else if (done && cur.op == op_sleep && sleep_cfg[SLEEP_EN_BIT])
				sleep_active <= 1'b1;
			if (start)
				break_hit <= 1'b0;
			else if (done && cur.op == op_break)
				break_hit <= 1'b1;
			wdt_restart <= done && cur.op == op_watchdog_restart;
			pm_write_pulse <= done && cur.op == op_program_memory_write;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wdt_count <= '0;
			wdt_timeout <= 1'b0;
		end else if (done && cur.op == op_watchdog_restart) begin
			wdt_count <= '0;
			wdt_timeout <= 1'b0;
		end else if (wdt_count == 32'(WDT_CYCLES - 1)) begin
			wdt_count <= '0;
			wdt_timeout <= 1'b1;
		end else begin
			wdt_count <= wdt_count + 32'h1;
			wdt_timeout <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic io_bit_now;
	assign io_bit_now = io_regs[io_addr][bit_sel];

	set_bit_time_a: assert property (start && cmd_in.op == op_set_io_bit |=> busy [*2] ##1 !busy)
		else $error("set-io-bit not two cycles");
	set_bit_value_a: assert property (done && cur.op == op_set_io_bit |=> io_bit_now && $stable(status_flags))
		else $error("set-io-bit wrong result");
	clear_bit_time_a: assert property (start && cmd_in.op == op_clear_io_bit |=> busy ##1 busy ##1 !busy)
		else $error("clear-io-bit not two cycles");
	clear_bit_value_a: assert property (done && cur.op == op_clear_io_bit |=> !io_bit_now && $stable(status_flags))
		else $error("clear-io-bit wrong result");
	shift_left_a: assert property (done && cur.op == op_shift_left_logical |=>
		src == {$past(src[6:0]), 1'b0} && status_flags[FLAG_C] == $past(src[7]))
		else $error("shift left wrong");
	shift_right_a: assert property (done && cur.op == op_shift_right_logical |=>
		src == {1'b0, $past(src[7:1])} && status_flags[FLAG_C] == $past(src[0]) && !status_flags[FLAG_N])
		else $error("shift right wrong");
	half_set_a: assert property (done && cur.op == op_set_half |=> status_flags == ($past(status_flags) | MASK_H))
		else $error("half-carry set disturbed flags");
	overflow_set_a: assert property (start && cmd_in.op == op_set_overflow
		|=> busy ##1 !busy && status_flags == ($past(status_flags) | MASK_V))
		else $error("overflow set wrong");
	post_inc_a: assert property (done && cur.op == op_load_post_inc && cur.rd < PTR_X_LOW
		|=> ptr_val == $past(ptr_val) + 16'h0001)
		else $error("post-increment pointer wrong");
	pre_dec_a: assert property (done && cur.op == op_load_pre_dec && cur.rd < PTR_X_LOW
		|=> ptr_val == $past(ptr_val) - 16'h0001 && src == $past(dmem[ea[DAW-1:0]]))
		else $error("pre-decrement load wrong");
	offset_keep_a: assert property (done && cur.op == op_load_with_offset && cur.rd < PTR_X_LOW |=> $stable(ptr_val))
		else $error("offset load moved pointer");
	pm_read_time_a: assert property (start && cmd_in.op == op_program_memory_read |=> busy [*3] ##1 !busy)
		else $error("program memory read not three cycles");
	push_sp_a: assert property (done && cur.op == op_push |=> sp == $past(sp) - 16'h0001)
		else $error("push stack pointer wrong");
	pop_sp_a: assert property (done && cur.op == op_pop |=> sp == $past(sp) + 16'h0001 && $stable(status_flags))
		else $error("pop stack pointer wrong");
	wdt_clear_a: assert property (done && cur.op == op_watchdog_restart |=> wdt_count == '0 && wdt_restart)
		else $error("watchdog not restarted");

	load_seen_c: cover property (start && cmd_in.op == op_load_post_inc ##2 !busy);
	push_pop_c: cover property (done && cur.op == op_push ##[1:20] done && cur.op == op_pop);
	sleep_c: cover property ($rose(sleep_active));
	bus_error_c: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule : cpu_bit_transfer_control_ops

// >>> cpu_ops_pkg.sv
// constants, opcodes and command layout for the bit, transfer and control execution unit
// assumes an AXI4-Lite master issues one command at a time through the command register
package cpu_ops_pkg;
	// register bus
	localparam int AXI_ADDR_W = 8;
	localparam logic [7:0] CMD_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] GPR_DATA_OFFSET = 8'h08;
	localparam logic [7:0] INDEX_OFFSET = 8'h0c;
	localparam logic [7:0] IO_DATA_OFFSET = 8'h10;
	localparam logic [7:0] SP_OFFSET = 8'h14;
	localparam logic [7:0] SLEEP_CFG_OFFSET = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// status flag positions and masks
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_H = 5;
	localparam logic [7:0] MASK_V = 8'h08;
	localparam logic [7:0] MASK_H = 8'h20;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	// pointer pairs and program-memory write source
	localparam logic [4:0] PTR_X_LOW = 5'h1a;
	localparam logic [4:0] PTR_Z_LOW = 5'h1e;
	localparam logic [4:0] PM_SRC_LOW = 5'h00;
	localparam logic [4:0] PM_SRC_HIGH = 5'h01;
	// sleep configuration
	localparam int SLEEP_EN_BIT = 0;
	localparam logic [3:0] SLEEP_CFG_RESET = 4'h0;
	localparam logic [7:0] INDEX_RESET = 8'h00;
	// instruction durations in core cycles
	localparam int CYCLES_SINGLE = 1;
	localparam int CYCLES_IO_BIT = 2;
	localparam int CYCLES_MEM = 2;
	localparam int CYCLES_PM_READ = 3;
	localparam int CYCLES_PM_WRITE = 2;
	typedef enum logic [4:0] {
		op_nop,
		op_set_io_bit,
		op_clear_io_bit,
		op_shift_left_logical,
		op_shift_right_logical,
		op_set_half,
		op_clear_half,
		op_set_overflow,
		op_load_post_inc,
		op_load_pre_dec,
		op_load_with_offset,
		op_load_direct,
		op_store_with_offset,
		op_store_direct,
		op_program_memory_read,
		op_push,
		op_pop,
		op_sleep,
		op_watchdog_restart,
		op_break,
		op_program_memory_write
	} op_type;
	typedef struct packed {
		logic [13:0] k;
		logic [5:0] q;
		logic [1:0] ptr;
		logic [4:0] rd;
		op_type op;
	} cmd_type;
endpackage : cpu_ops_pkg

// >>> test_cpu_bit_transfer_control_ops.sv
// self-checking bench: axi4-lite register access drives instructions through the command register
// assumes the package register map and command layout; watchdog shortened to 20 cycles
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module test_cpu_bit_transfer_control_ops;
	import cpu_ops_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, sleep_active, wdt_restart, wdt_timeout, break_hit, pm_write_pulse;
	logic [1:0] bresp, rresp;
	logic [2:0] sleep_mode;
	logic [31:0] v;
	logic [1:0] resp;
	int errors = 0, compares = 0, restarts, timeouts, pm_writes, t0;
	always #50 aclk = ~aclk;
	cpu_bit_transfer_control_ops #(.WDT_CYCLES(20)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sleep_active(sleep_active), .sleep_mode(sleep_mode),
		.wdt_restart(wdt_restart), .wdt_timeout(wdt_timeout), .break_hit(break_hit),
		.pm_write_pulse(pm_write_pulse));
	core_side_monitor far (.aclk(aclk), .aresetn(aresetn), .wdt_restart(wdt_restart),
		.wdt_timeout(wdt_timeout), .pm_write_pulse(pm_write_pulse), .restarts(restarts),
		.timeouts(timeouts), .pm_writes(pm_writes));
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up
	task automatic hang();
		errors++;
		$display("mismatch handshake expected done seen timeout");
		wrap_up();
	endtask : hang
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (++n > 50) hang();
		end while ((awvalid & !ta) | (wvalid & !tw));
		do begin
			@(negedge aclk);
			if (++n > 50) hang();
		end while (bvalid !== 1'b1);
		resp = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta;
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arready;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (++n > 50) hang();
		end while (!ta);
		while (rvalid !== 1'b1) begin
			@(negedge aclk);
			if (++n > 50) hang();
		end
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : axi_read
	task automatic set_reg(input logic [7:0] idx, input logic [7:0] val, input logic [7:0] off);
		axi_write(INDEX_OFFSET, {24'h0, idx});
		axi_write(off, {24'h0, val});
	endtask : set_reg
	task automatic get_reg(input logic [7:0] idx, input logic [7:0] off);
		axi_write(INDEX_OFFSET, {24'h0, idx});
		axi_read(off, v, resp);
	endtask : get_reg
	task automatic run(input op_type op, input logic [4:0] rd, input logic [1:0] ptr,
		input logic [5:0] q, input logic [13:0] k);
		cmd_type c;
		int n;
		c = '{k: k, q: q, ptr: ptr, rd: rd, op: op};
		axi_write(CMD_OFFSET, 32'(c));
		n = 0;
		do begin
			axi_read(STATUS_OFFSET, v, resp);
			if (++n > 20) hang();
		end while (v[8] !== 1'b0);
	endtask : run
	task automatic flags_are(input logic [7:0] f);
		axi_read(STATUS_OFFSET, v, resp);
		`CHK("flags", f, v[7:0])
	endtask : flags_are
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(SP_OFFSET, v, resp);
		`CHK("stack pointer reset", 32'h3f, v)
		flags_are(8'h00);
		axi_read(8'h1c, v, resp);
		`CHK("unmapped response", RESP_SLVERR, resp)
		`CHK("unmapped read data", 32'h0, v)
		axi_write(8'h1c, 32'h0);
		`CHK("unmapped write response", RESP_SLVERR, resp)
		$display("test reset and map done");
		set_reg(8'h05, 8'h00, IO_DATA_OFFSET);
		run(op_set_io_bit, 5'h0, 2'h0, 6'h05, 14'h3);
		get_reg(8'h05, IO_DATA_OFFSET);
		`CHK("io set", 32'h08, v)
		set_reg(8'h05, 8'hff, IO_DATA_OFFSET);
		run(op_clear_io_bit, 5'h0, 2'h0, 6'h05, 14'h7);
		get_reg(8'h05, IO_DATA_OFFSET);
		`CHK("io clear", 32'h7f, v)
		flags_are(8'h00);
		$display("test io bits done");
		set_reg(8'h10, 8'h81, GPR_DATA_OFFSET);
		run(op_shift_left_logical, 5'h10, 2'h0, 6'h0, 14'h0);
		get_reg(8'h10, GPR_DATA_OFFSET);
		`CHK("shift left", 32'h02, v)
		flags_are(8'h09);
		run(op_shift_right_logical, 5'h10, 2'h0, 6'h0, 14'h0);
		flags_are(8'h00);
		run(op_set_overflow, 5'h0, 2'h0, 6'h0, 14'h0);
		flags_are(8'h08);
		run(op_set_half, 5'h0, 2'h0, 6'h0, 14'h0);
		flags_are(8'h28);
		run(op_clear_half, 5'h0, 2'h0, 6'h0, 14'h0);
		flags_are(8'h08);
		run(op_shift_right_logical, 5'h10, 2'h0, 6'h0, 14'h0);
		flags_are(8'h0b);
		run(op_shift_right_logical, 5'h10, 2'h0, 6'h0, 14'h0);
		get_reg(8'h10, GPR_DATA_OFFSET);
		`CHK("shift right to zero", 32'h00, v)
		flags_are(8'h02);
		$display("test shifts and flags done");
		set_reg(8'h02, 8'ha5, GPR_DATA_OFFSET);
		set_reg(8'h05, 8'h3c, GPR_DATA_OFFSET);
		set_reg(8'h1a, 8'h10, GPR_DATA_OFFSET);
		set_reg(8'h1b, 8'h00, GPR_DATA_OFFSET);
		set_reg(8'h1c, 8'h10, GPR_DATA_OFFSET);
		set_reg(8'h1d, 8'h00, GPR_DATA_OFFSET);
		run(op_store_direct, 5'h02, 2'h0, 6'h0, 14'h10);
		run(op_load_post_inc, 5'h03, 2'h0, 6'h0, 14'h0);
		get_reg(8'h03, GPR_DATA_OFFSET);
		`CHK("post-inc data", 32'ha5, v)
		get_reg(8'h1a, GPR_DATA_OFFSET);
		`CHK("post-inc pointer", 32'h11, v)
		run(op_load_pre_dec, 5'h04, 2'h0, 6'h0, 14'h0);
		get_reg(8'h04, GPR_DATA_OFFSET);
		`CHK("pre-dec data", 32'ha5, v)
		get_reg(8'h1a, GPR_DATA_OFFSET);
		`CHK("pre-dec pointer", 32'h10, v)
		run(op_store_with_offset, 5'h05, 2'h0, 6'h03, 14'h0);
		run(op_load_direct, 5'h06, 2'h0, 6'h0, 14'h13);
		get_reg(8'h06, GPR_DATA_OFFSET);
		`CHK("offset store direct load", 32'h3c, v)
		run(op_load_with_offset, 5'h07, 2'h1, 6'h03, 14'h0);
		get_reg(8'h07, GPR_DATA_OFFSET);
		`CHK("offset load", 32'h3c, v)
		get_reg(8'h1c, GPR_DATA_OFFSET);
		`CHK("offset pointer kept", 32'h10, v)
		flags_are(8'h02);
		$display("test data transfer done");
		set_reg(8'h00, 8'h34, GPR_DATA_OFFSET);
		set_reg(8'h01, 8'h12, GPR_DATA_OFFSET);
		set_reg(8'h1e, 8'h04, GPR_DATA_OFFSET);
		set_reg(8'h1f, 8'h00, GPR_DATA_OFFSET);
		run(op_program_memory_write, 5'h0, 2'h2, 6'h0, 14'h0);
		`CHK("pm write pulses", 1, pm_writes)
		run(op_program_memory_read, 5'h08, 2'h2, 6'h0, 14'h0);
		run(op_program_memory_read, 5'h09, 2'h2, 6'h0, 14'h0);
		get_reg(8'h08, GPR_DATA_OFFSET);
		`CHK("pm low byte", 32'h34, v)
		get_reg(8'h09, GPR_DATA_OFFSET);
		`CHK("pm high byte", 32'h12, v)
		get_reg(8'h1e, GPR_DATA_OFFSET);
		`CHK("pm pointer", 32'h06, v)
		run(op_push, 5'h02, 2'h0, 6'h0, 14'h0);
		axi_read(SP_OFFSET, v, resp);
		`CHK("push stack pointer", 32'h3e, v)
		axi_write(SP_OFFSET, 32'h0);
		`CHK("stack pointer write response", RESP_OKAY, resp)
		run(op_pop, 5'h0a, 2'h0, 6'h0, 14'h0);
		axi_read(SP_OFFSET, v, resp);
		`CHK("pop stack pointer", 32'h3f, v)
		get_reg(8'h0a, GPR_DATA_OFFSET);
		`CHK("pop data", 32'ha5, v)
		$display("test program memory and stack done");
		axi_write(SLEEP_CFG_OFFSET, 32'h5);
		run(op_sleep, 5'h0, 2'h0, 6'h0, 14'h0);
		axi_read(STATUS_OFFSET, v, resp);
		`CHK("sleep status", 3'b010, v[10:8])
		`CHK("sleep mode", 3'h2, sleep_mode)
		`CHK("sleep pin", 1'b1, sleep_active)
		run(op_break, 5'h0, 2'h0, 6'h0, 14'h0);
		axi_read(STATUS_OFFSET, v, resp);
		`CHK("break status", 11'h402, v[10:0])
		`CHK("break pin", 1'b1, break_hit)
		t0 = timeouts;
		run(op_watchdog_restart, 5'h0, 2'h0, 6'h0, 14'h0);
		t0 = timeouts;
		repeat (8) @(posedge aclk);
		`CHK("watchdog restarts", 1, restarts)
		`CHK("no early timeout", t0, timeouts)
		repeat (20) @(posedge aclk);
		`CHK("timeout after idle", t0 + 1, timeouts)
		flags_are(8'h02);
		$display("test core control done");
		wrap_up();
	end
endmodule : test_cpu_bit_transfer_control_ops
